/* File: hw/event_entry_params.svh */
`ifndef EVENT_ENTRY_PARAMS_SVH
`define EVENT_ENTRY_PARAMS_SVH
// Function
// - Reset clears state, loads status reset value, fetch starts at A000_0000, unmaskable.
// - ITLB miss enters at base OR 50, supervisor call at base OR 100.
// - Autovector offset bus is 14 bits wide, offsets up to 16383 bytes.
// - Interrupt handler address is vector base OR autovector offset, never a sum.
// - Events of the oldest instruction in the pipeline are always served first.
// - Within one instruction, a fixed 27-level priority picks the event.
// - Return address: first open or first unissued instruction, faulting one, or supervisor call plus 2.
// - Debug stop saves status and PC to debug copies, mode 110, sets masks.
// - Exception while exception mask set becomes unrecoverable, mode 110, base OR 00.
// - Multiple TLB hit masks interrupts, records address and TLB, base OR 04.
// - Multiple TLB hit leaves the address space tag of entry high untouched.
// - Data bus error saves first unissued PC, mode 110, masks, base OR 08.
// - Fetch bus error saves faulting fetch PC, mode 110, masks, base OR 0C.
// - Accepting an interrupt sets mask bits of equal and lower levels; other events set EM and GM.
`define RESET_PC 32'hA000_0000
`define SR_RESET 32'h003F_0000
`define SR_R 15
`define SR_GM 16
`define SR_I0M 17
`define SR_I1M 18
`define SR_I2M 19
`define SR_I3M 20
`define SR_EM 21
`define SR_M_LO 22
`define SR_M_HI 24
`define SR_D 26
`define SR_DM 27
`define SR_J 28
`define MODE_EXC 3'h6
`define MODE_NMI 3'h7
`define MODE_INT3 3'h5
`define MODE_INT2 3'h4
`define MODE_INT1 3'h3
`define MODE_INT0 3'h2
`define EV_N 28
`define EV_DBG 5'h01
`define EV_UNREC 5'h02
`define EV_MHIT 5'h03
`define EV_BUSD 5'h04
`define EV_BUSI 5'h05
`define EV_NMI 5'h06
`define EV_INT3 5'h07
`define EV_INT2 5'h08
`define EV_INT1 5'h09
`define EV_INT0 5'h0A
`define EV_IADDR 5'h0B
`define EV_ITLB_MISS 5'h0C
`define EV_ITLB_PROT 5'h0D
`define EV_BRK 5'h0E
`define EV_SCALL 5'h14
`define EV_DADDR_R 5'h15
`define VEC_W 12
`define VEC_TABLE {12'h044, 12'h040, 12'h03C, 12'h070, 12'h060, 12'h038, 12'h034, 12'h100, 12'h030, 12'h02C,\
 12'h028, 12'h024, 12'h020, 12'h01C, 12'h018, 12'h050, 12'h014, 12'h000, 12'h000, 12'h000, 12'h000, 12'h010,\
 12'h00C, 12'h008, 12'h004, 12'h000, 12'h000, 12'h000}
`define VEC_ITLB_MISS 32'h0000_0050
`define SCALL_STEP 32'h0000_0002
`define AV_W 14
`define STG_W 8
`define VPN_LO 10
`define TLB_I 8
`define ADDRESS_SPACE_TAG_HI 7
`define ADDRESS_SPACE_TAG_LO 0
`define HOLDOFF 2'h3
`define SYNC_N 6
`define IRQ_N 4
`define IRQ_TAKEN 0
`define IRQ_UNREC 1
`define IRQ_MHIT 2
`define IRQ_BUSERR 3
`define ADDR_SR 8'h00
`define ADDR_VBP 8'h04
`define ADDR_EXC_SR 8'h08
`define ADDR_EXC_PC 8'h0C
`define ADDR_DBG_SR 8'h10
`define ADDR_DBG_PC 8'h14
`define ADDR_TLB_FA 8'h18
`define ADDR_TLB_EH 8'h1C
`define ADDR_IRQ_ST 8'h20
`define ADDR_IRQ_MASK 8'h24
`endif

/* File: hw/event_entry_pkg.sv */
package event_entry_pkg;
`include "event_entry_params.svh"
    typedef struct packed {
        logic boot;
        logic [1:0] holdoff;
        logic [`SYNC_N-1:0] sync1;
        logic [`SYNC_N-1:0] sync2;
        logic [31:0] sr;
        logic [31:0] vbp;
        logic [31:0] exc_sr;
        logic [31:0] exc_pc;
        logic [31:0] dbg_sr;
        logic [31:0] dbg_pc;
        logic [31:0] tlb_fa;
        logic [31:0] tlb_eh;
        logic [31:0] rdata;
        logic [31:0] redir_pc;
        logic [`IRQ_N-1:0] irq_st;
        logic [`IRQ_N-1:0] irq_mask;
        logic redirect;
        logic flush;
        logic accept;
        logic irq;
        logic [4:0] acc_idx;
        logic [`STG_W-1:0] acc_stg;
    } state_t;
endpackage : event_entry_pkg

/* File: hw/event_entry_vectoring.sv */
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "event_entry_params.svh"
module event_entry_vectoring
    import event_entry_pkg::*;
#(
    parameter int NSTAGE = 2,
    parameter int AV_BITS = `AV_W
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [NSTAGE-1:0][`EV_N-1:0] stage_ev_in,
    input wire logic [NSTAGE-1:0][31:0] stage_pc_in,
    input wire logic dbg_stop_in,
    input wire logic nmi_in,
    input wire logic [3:0] irq_lvl_in,
    input wire logic bus_err_data_in,
    input wire logic [AV_BITS-1:0] autovector_in,
    input wire logic [31:0] open_pc_in,
    input wire logic [31:0] unissued_pc_in,
    input wire logic [31:0] fault_va_in,
    input wire logic fault_itlb_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic redirect_out,
    output logic [31:0] redirect_pc_out,
    output logic flush_out,
    output logic accept_out,
    output logic [4:0] accept_idx_out,
    output logic [`STG_W-1:0] accept_stage_out,
    output logic [31:0] status_word_out,
    output logic debug_halt_out,
    output logic irq_out
);
    localparam logic [`EV_N*`VEC_W-1:0] VEC_TAB = `VEC_TABLE;

    // Refuse shapes the selector and offset bus cannot serve
    generate
        if (NSTAGE < 1 || NSTAGE > (1 << `STG_W))
        begin : g_bad_stages
            $error("NSTAGE out of range");
        end
        if (AV_BITS != `AV_W)
        begin : g_bad_av
            $error("autovector width must be 14");
        end
    endgenerate

    state_t st_r;
    state_t nxt;
    sel_if #(.NSTAGE(NSTAGE)) sel ();

    event_select #(.NSTAGE(NSTAGE)) u_select (
        .sel(sel)
    );

    // Events tied to an instruction save its address, supervisor call +2; asynchronous ones and EV_BRK the first open, data bus error the first unissued
    function automatic logic [31:0] ret_pc(input logic [4:0] i, input logic [31:0] own,
                                          input logic [31:0] open, input logic [31:0] unissued);
        case (i)
            `EV_DBG, `EV_NMI, `EV_INT3, `EV_INT2, `EV_INT1, `EV_INT0, `EV_BRK: ret_pc = open;
            `EV_BUSD: ret_pc = unissued;
            `EV_SCALL: ret_pc = own + `SCALL_STEP;
            default: ret_pc = own;
        endcase
    endfunction : ret_pc

    // New status on entry: R and J cleared, mode and mask bits by event
    function automatic logic [31:0] sr_enter(input logic [31:0] sr, input logic [4:0] i);
        logic [31:0] s;
        s = sr;
        s[`SR_R] = 1'b0;
        s[`SR_J] = 1'b0;
        s[`SR_M_HI:`SR_M_LO] = `MODE_EXC;
        case (i)
            `EV_DBG, `EV_BRK:
            begin
                s[`SR_D] = 1'b1;
                s[`SR_DM] = 1'b1;
                s[`SR_EM] = 1'b1;
                s[`SR_GM] = 1'b1;
            end
            `EV_NMI:
            begin
                s[`SR_M_HI:`SR_M_LO] = `MODE_NMI;
                s[`SR_EM] = 1'b1;
                s[`SR_GM] = 1'b1;
            end
            `EV_INT3:
            begin
                s[`SR_M_HI:`SR_M_LO] = `MODE_INT3;
                s[`SR_I3M:`SR_I0M] = 4'hF;
            end
            `EV_INT2:
            begin
                s[`SR_M_HI:`SR_M_LO] = `MODE_INT2;
                s[`SR_I2M:`SR_I0M] = 3'h7;
            end
            `EV_INT1:
            begin
                s[`SR_M_HI:`SR_M_LO] = `MODE_INT1;
                s[`SR_I1M:`SR_I0M] = 2'h3;
            end
            `EV_INT0:
            begin
                s[`SR_M_HI:`SR_M_LO] = `MODE_INT0;
                s[`SR_I0M] = 1'b1;
            end
            default:
            begin
                s[`SR_EM] = 1'b1;
                s[`SR_GM] = 1'b1;
            end
        endcase
        sr_enter = s;
    endfunction : sr_enter

    // Events that load the MMU fault registers
    function automatic logic tlb_event(input logic [4:0] i);
        tlb_event = (i == `EV_MHIT) || (i >= `EV_IADDR && i <= `EV_ITLB_PROT) || (i >= `EV_DADDR_R);
    endfunction : tlb_event

    function automatic logic is_int(input logic [4:0] i);
        is_int = (i >= `EV_INT3) && (i <= `EV_INT0);
    endfunction : is_int

    // Pin-level requests are synchronised; stage and bus error requests are same-clock logic
    always_comb
    begin
        sel.ev = stage_ev_in;
        sel.ev[0][0] = 1'b0;
        sel.ev[0][`EV_DBG] = stage_ev_in[0][`EV_DBG] | (st_r.sync2[5] & ~st_r.sr[`SR_D]);
        sel.ev[0][`EV_NMI] = stage_ev_in[0][`EV_NMI] | st_r.sync2[4];
        sel.ev[0][`EV_INT3] = stage_ev_in[0][`EV_INT3] | st_r.sync2[3];
        sel.ev[0][`EV_INT2] = stage_ev_in[0][`EV_INT2] | st_r.sync2[2];
        sel.ev[0][`EV_INT1] = stage_ev_in[0][`EV_INT1] | st_r.sync2[1];
        sel.ev[0][`EV_INT0] = stage_ev_in[0][`EV_INT0] | st_r.sync2[0];
        sel.ev[0][`EV_BUSD] = stage_ev_in[0][`EV_BUSD] | bus_err_data_in;
        sel.sr = st_r.sr;
    end

    // Whole next state; one accepted event lands in a single edge
    always_comb
    begin
        logic take;
        logic [31:0] own_pc;
        take = 1'b0;
        own_pc = '0;
        nxt = st_r;
        nxt.sync1 = {dbg_stop_in, nmi_in, irq_lvl_in};
        nxt.sync2 = st_r.sync1;
        nxt.redirect = 1'b0;
        nxt.flush = 1'b0;
        nxt.accept = 1'b0;
        nxt.rdata = '0;
        if (st_r.holdoff != 2'h0)
        begin
            nxt.holdoff = st_r.holdoff - 2'h1;
        end
        // Register reads; data stands one cycle, a read of the interrupt status clears it
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                `ADDR_SR: nxt.rdata = st_r.sr;
                `ADDR_VBP: nxt.rdata = st_r.vbp;
                `ADDR_EXC_SR: nxt.rdata = st_r.exc_sr;
                `ADDR_EXC_PC: nxt.rdata = st_r.exc_pc;
                `ADDR_DBG_SR: nxt.rdata = st_r.dbg_sr;
                `ADDR_DBG_PC: nxt.rdata = st_r.dbg_pc;
                `ADDR_TLB_FA: nxt.rdata = st_r.tlb_fa;
                `ADDR_TLB_EH: nxt.rdata = st_r.tlb_eh;
                `ADDR_IRQ_ST:
                begin
                    nxt.rdata = {{(32-`IRQ_N){1'b0}}, st_r.irq_st};
                    nxt.irq_st = '0;
                end
                `ADDR_IRQ_MASK: nxt.rdata = {{(32-`IRQ_N){1'b0}}, st_r.irq_mask};
                default: nxt.rdata = '0;
            endcase
        end
        // Register writes; an entry in the same cycle overrides a status write
        if (reg_wr_in)
        begin
            case (reg_addr_in)
                `ADDR_SR: nxt.sr = reg_wdata_in;
                `ADDR_VBP: nxt.vbp = reg_wdata_in;
                `ADDR_TLB_EH: nxt.tlb_eh[`ADDRESS_SPACE_TAG_HI:`ADDRESS_SPACE_TAG_LO] = reg_wdata_in[`ADDRESS_SPACE_TAG_HI:`ADDRESS_SPACE_TAG_LO];
                `ADDR_IRQ_MASK: nxt.irq_mask = reg_wdata_in[`IRQ_N-1:0];
                default: ;
            endcase
        end
        // First cycle after reset release sends fetch to the fixed reset address
        if (st_r.boot)
        begin
            nxt.boot = 1'b0;
            nxt.redirect = 1'b1;
            nxt.redir_pc = `RESET_PC;
            nxt.flush = 1'b1;
        end
        // Hold-off covers source latency and the synchroniser, so a held request is not taken twice
        else if (sel.hit && st_r.holdoff == 2'h0)
        begin
            take = 1'b1;
        end
        if (take)
        begin
            own_pc = stage_pc_in[sel.stg];
            nxt.holdoff = `HOLDOFF;
            nxt.accept = 1'b1;
            nxt.acc_idx = sel.idx;
            nxt.acc_stg = sel.stg;
            nxt.flush = 1'b1;
            if (sel.idx == `EV_DBG || sel.idx == `EV_BRK)
            begin
                nxt.dbg_sr = st_r.sr;
                nxt.dbg_pc = ret_pc(sel.idx, own_pc, open_pc_in, unissued_pc_in);
            end
            else
            begin
                nxt.exc_sr = st_r.sr;
                nxt.exc_pc = ret_pc(sel.idx, own_pc, open_pc_in, unissued_pc_in);
            end
            nxt.sr = sr_enter(st_r.sr, sel.idx);
            // Debug stop leaves the PC to the debugger, which then drives the pipeline
            if (sel.idx != `EV_DBG)
            begin
                nxt.redirect = 1'b1;
            end
            if (is_int(sel.idx))
            begin
                // Offset trusted as given by the controller; OR saves an adder, base must be aligned
                nxt.redir_pc = st_r.vbp | {{(32-`AV_W){1'b0}}, autovector_in};
            end
            else
            begin
                nxt.redir_pc = st_r.vbp | {{(32-`VEC_W){1'b0}}, VEC_TAB[sel.idx*`VEC_W +: `VEC_W]};
            end
            // Fault address capture; the address space tag is never touched here
            if (tlb_event(sel.idx))
            begin
                nxt.tlb_fa = fault_va_in;
                nxt.tlb_eh[31:`VPN_LO] = fault_va_in[31:`VPN_LO];
                nxt.tlb_eh[`TLB_I] = (sel.idx == `EV_MHIT) ? fault_itlb_in : (sel.idx <= `EV_ITLB_PROT);
            end
            // Sticky flags set after the read clear, so a set in the clearing cycle survives
            nxt.irq_st[`IRQ_TAKEN] = 1'b1;
            if (sel.idx == `EV_UNREC)
            begin
                nxt.irq_st[`IRQ_UNREC] = 1'b1;
            end
            if (sel.idx == `EV_MHIT)
            begin
                nxt.irq_st[`IRQ_MHIT] = 1'b1;
            end
            if (sel.idx == `EV_BUSD || sel.idx == `EV_BUSI)
            begin
                nxt.irq_st[`IRQ_BUSERR] = 1'b1;
            end
        end
        nxt.irq = |(nxt.irq_st & nxt.irq_mask);
    end

    // Single state register; clock enable freezes everything
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_r <= '0;
            st_r.boot <= 1'b1;
            st_r.sr <= `SR_RESET;
        end
        else if (ce_in)
        begin
            st_r <= nxt;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata_out = st_r.rdata;
    assign redirect_out = st_r.redirect;
    assign redirect_pc_out = st_r.redir_pc;
    assign flush_out = st_r.flush;
    assign accept_out = st_r.accept;
    assign accept_idx_out = st_r.acc_idx;
    assign accept_stage_out = st_r.acc_stg;
    assign status_word_out = st_r.sr;
    assign debug_halt_out = st_r.sr[`SR_D];
    assign irq_out = st_r.irq;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    reset_fetch_a: assert property ((st_r.boot && ce_in) |=> (redirect_out && redirect_pc_out == `RESET_PC))
        else $error("reset fetch address wrong");
    itlb_vector_a: assert property ((nxt.accept && ce_in && sel.idx == `EV_ITLB_MISS)
        |=> redirect_pc_out == ($past(st_r.vbp) | `VEC_ITLB_MISS))
        else $error("ITLB miss vector wrong");
    autovec_or_a: assert property ((nxt.accept && ce_in && is_int(sel.idx))
        |=> redirect_pc_out == ($past(st_r.vbp) | {{(32-`AV_W){1'b0}}, $past(autovector_in)}))
        else $error("autovector address not an OR");
    oldest_first_a: assert property ((nxt.accept && stage_ev_in[0][`EV_DBG]) |-> sel.stg == '0)
        else $error("younger stage taken first");
    fixed_order_a: assert property ((nxt.accept && sel.stg == '0 && sel.ev[0][`EV_BUSD])
        |-> sel.idx <= `EV_BUSD)
        else $error("lower priority event chosen");
    scall_return_a: assert property ((nxt.accept && ce_in && sel.idx == `EV_SCALL)
        |=> st_r.exc_pc == $past(stage_pc_in[sel.stg]) + `SCALL_STEP)
        else $error("supervisor call return address wrong");
    debug_entry_a: assert property ((nxt.accept && ce_in && sel.idx == `EV_DBG)
        |=> (st_r.dbg_sr == $past(st_r.sr) && st_r.sr[`SR_M_HI:`SR_M_LO] == `MODE_EXC
             && st_r.sr[`SR_D] && st_r.sr[`SR_DM] && !redirect_out))
        else $error("debug stop entry wrong");
    unrec_entry_a: assert property ((nxt.accept && ce_in && sel.idx >= `EV_IADDR && sel.sr[`SR_EM])
        |-> sel.idx == `EV_UNREC)
        else $error("masked exception not unrecoverable");
    mhit_tag_a: assert property ((nxt.accept && ce_in && sel.idx == `EV_MHIT)
        |=> (st_r.tlb_eh[`ADDRESS_SPACE_TAG_HI:`ADDRESS_SPACE_TAG_LO] == $past(st_r.tlb_eh[`ADDRESS_SPACE_TAG_HI:`ADDRESS_SPACE_TAG_LO]) && st_r.sr[`SR_GM]))
        else $error("multiple hit entry wrong");
    busd_return_a: assert property ((nxt.accept && ce_in && sel.idx == `EV_BUSD)
        |=> st_r.exc_pc == $past(unissued_pc_in))
        else $error("data bus error return address wrong");
    atomic_step_a: assert property (accept_out |-> flush_out)
        else $error("entry without flush");
endmodule : event_entry_vectoring

/* File: hw/event_select.sv */
`timescale 1ns/1ps
`include "event_entry_params.svh"
module event_select
    import event_entry_pkg::*;
#(
    parameter int NSTAGE = 2
)
(
    sel_if.pick sel
);
    // Mask test per event; critical events never report masked
    function automatic logic ev_masked(input logic [4:0] i, input logic [31:0] sr);
        case (i)
            `EV_NMI: ev_masked = (sr[`SR_M_HI:`SR_M_LO] == `MODE_NMI);
            `EV_INT3: ev_masked = sr[`SR_GM] | sr[`SR_I3M];
            `EV_INT2: ev_masked = sr[`SR_GM] | sr[`SR_I2M];
            `EV_INT1: ev_masked = sr[`SR_GM] | sr[`SR_I1M];
            `EV_INT0: ev_masked = sr[`SR_GM] | sr[`SR_I0M];
            `EV_BRK: ev_masked = sr[`SR_DM];
            default: ev_masked = 1'b0;
        endcase
    endfunction : ev_masked

    // Oldest stage first, then lowest index; bit 0 is reset and never taken here
    always_comb
    begin
        logic hit_v;
        logic [4:0] idx_v;
        logic [`STG_W-1:0] stg_v;
        hit_v = 1'b0;
        idx_v = '0;
        stg_v = '0;
        for (int s = 0; s < NSTAGE; s++)
        begin
            for (int i = 1; i < `EV_N; i++)
            begin
                if (!hit_v && sel.ev[s][i] && !ev_masked(5'(i), sel.sr))
                begin
                    hit_v = 1'b1;
                    idx_v = 5'(i);
                    stg_v = `STG_W'(s);
                end
            end
        end
        // An exception met while exceptions are masked cannot be served normally
        if (hit_v && idx_v >= `EV_IADDR && sel.sr[`SR_EM])
        begin
            idx_v = `EV_UNREC;
        end
        sel.hit = hit_v;
        sel.idx = idx_v;
        sel.stg = stg_v;
    end
endmodule : event_select

/* File: hw/sel_if.sv */
`timescale 1ns/1ps
`include "event_entry_params.svh"
interface sel_if #(parameter int NSTAGE = 2);
    logic [NSTAGE-1:0][`EV_N-1:0] ev;
    logic [31:0] sr;
    logic hit;
    logic [4:0] idx;
    logic [`STG_W-1:0] stg;
    modport pick (input ev, input sr, output hit, output idx, output stg);
    modport core (output ev, output sr, input hit, input idx, input stg);
endinterface : sel_if

/* File: tb/event_entry_vectoring_tb_top.sv */
`timescale 1ns/1ps
module event_entry_vectoring_tb_top;
    import event_entry_pkg::*;
    logic clk_in = 0, rst_n_in = 0, ce_in = 1, dbg = 0, berr = 0, fitlb = 0, wr = 0, rd = 0, acc, redir, halt, irq;
    logic nmi = 0, fl;
    logic [1:0][27:0] ev = '0;
    logic [1:0][31:0] spc = '0;
    logic [3:0] raise = 4'h0, lvl;
    logic [13:0] av;
    logic [31:0] opc = 32'h8000_0400, upc = 32'h8000_0300, fva = 32'h1234_5C00, wd = 0, rdat, rpc, sw, d;
    logic [7:0] addr = 0, stg;
    logic [4:0] idx;
    int num_errors = 0, tests_run = 0;
    event_entry_vectoring #(.NSTAGE(2)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .stage_ev_in(ev), .stage_pc_in(spc), .dbg_stop_in(dbg), .nmi_in(nmi), .irq_lvl_in(lvl),
        .bus_err_data_in(berr), .autovector_in(av), .open_pc_in(opc), .unissued_pc_in(upc), .fault_va_in(fva),
        .fault_itlb_in(fitlb), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdat), .redirect_out(redir), .redirect_pc_out(rpc), .flush_out(fl), .accept_out(acc),
        .accept_idx_out(idx), .accept_stage_out(stg), .status_word_out(sw), .debug_halt_out(halt), .irq_out(irq));
    irq_ctrl_model icm (.clk_in(clk_in), .rst_n_in(rst_n_in), .raise_in(raise), .accept_in(acc),
        .accept_idx_in(idx), .irq_lvl_out(lvl), .autovector_out(av));
    // Free-running 50 MHz clock
    initial
    begin
        forever #10 clk_in = ~clk_in;
    end
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task complete_run;
        $display("Checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    task reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask : reg_wr
    // Read data stands only in the cycle after the strobe
    task reg_rd(input logic [7:0] a);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 d = rdat;
    endtask : reg_rd
    // Waits for a bounded time for the entry, then drops the stage, bus error, debug and NMI requests
    task entry(input string nm, input logic [4:0] ei, input logic [31:0] pc, input logic [31:0] ret);
        int n;
        n = 0;
        do
        begin
            @(posedge clk_in);
            #1 n++;
        end
        while (acc !== 1'b1 && n < 40);
        check({nm, " idx"}, 32'(idx), 32'(ei));
        check({nm, " pc"}, rpc, pc);
        check({nm, " flush"}, 32'(fl), 32'h1);
        @(posedge clk_in);
        ev <= '0;
        berr <= 1'b0;
        dbg <= 1'b0;
        nmi <= 1'b0;
        reg_rd(8'h0C);
        check({nm, " ret"}, d, ret);
        $display("Done %s", nm);
    endtask : entry
    task t_itlb;
        spc[0] <= 32'h8000_0010;
        ev[0][12] <= 1'b1;
        entry("itlb", 5'h0C, 32'h0000_1250, 32'h8000_0010);
        check("itlb sr", sw, 32'h01A1_0000);
        check("irq on", 32'(irq), 32'h1);
        reg_rd(8'h20);
        check("irq st", d & 32'h1, 32'h1);
        @(posedge clk_in);
        #1 check("irq off", 32'(irq), 32'h0);
        spc[0] <= 32'h8000_0020;
        ev[0][13] <= 1'b1;
        entry("unrec", 5'h02, 32'h0000_1200, 32'h8000_0020);
    endtask : t_itlb
    task t_age;
        reg_wr(8'h00, 32'h0);
        spc <= {32'h8000_0104, 32'h8000_0100};
        ev[1][3] <= 1'b1;
        ev[0][20] <= 1'b1;
        entry("age", 5'h14, 32'h0000_1300, 32'h8000_0102);
        check("age stg", 32'(stg), 32'h0);
        reg_wr(8'h00, 32'h0);
        spc[0] <= 32'h8000_0200;
        ev[0][14] <= 1'b1;
        ev[0][12] <= 1'b1;
        ev[0][3] <= 1'b1;
        entry("mhit", 5'h03, 32'h0000_1204, 32'h8000_0200);
        reg_rd(8'h18);
        check("mhit va", d, 32'h1234_5C00);
        reg_rd(8'h1C);
        check("mhit eh", d, 32'h1234_5D5A);
    endtask : t_age
    task t_bus;
        reg_wr(8'h00, 32'h0);
        berr <= 1'b1;
        ev[0][11] <= 1'b1;
        entry("bus data", 5'h04, 32'h0000_1208, 32'h8000_0300);
        reg_wr(8'h00, 32'h0);
        spc[1] <= 32'h8000_0500;
        ev[1][5] <= 1'b1;
        entry("bus fetch", 5'h05, 32'h0000_120C, 32'h8000_0500);
        check("fetch stg", 32'(stg), 32'h1);
        reg_wr(8'h00, 32'h0);
        nmi <= 1'b1;
        entry("nmi", 5'h06, 32'h0000_1210, 32'h8000_0400);
        check("nmi sr", sw & 32'h01E1_0000, 32'h01E1_0000);
    endtask : t_bus
    task t_irq_dbg;
        int n;
        reg_wr(8'h00, 32'h0);
        raise <= 4'h8;
        @(posedge clk_in);
        raise <= 4'h0;
        entry("int3", 5'h07, 32'h0000_1280, 32'h8000_0400);
        check("int masks", sw & 32'h01DF_0000, 32'h015E_0000);
        // R and J set beforehand so that the entry has to clear them
        reg_wr(8'h00, 32'h1000_8000);
        dbg <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_in);
            #1 n++;
        end
        while (acc !== 1'b1 && n < 40);
        check("dbg idx", 32'(idx), 32'h1);
        check("dbg redir", 32'(redir), 32'h0);
        check("dbg sr", sw & 32'h1DE1_8000, 32'h0DA1_0000);
        check("dbg halt", 32'(halt), 32'h1);
        @(posedge clk_in);
        dbg <= 1'b0;
        reg_rd(8'h14);
        check("dbg ret", d, 32'h8000_0400);
        reg_rd(8'h10);
        check("dbg saved sr", d, 32'h1000_8000);
        $display("Done debug");
    endtask : t_irq_dbg
    initial
    begin
        #100000 num_errors++;
        complete_run();
    end
    initial
    begin
        repeat (15) @(posedge clk_in);
        #1 check("rst sr", sw, 32'h003F_0000);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        #1 check("boot redir", 32'(redir), 32'h1);
        check("boot pc", rpc, 32'hA000_0000);
        reg_wr(8'h04, 32'h0000_1200);
        // A write while the clock enable is low must not land
        ce_in <= 1'b0;
        reg_wr(8'h04, 32'h0000_3400);
        ce_in <= 1'b1;
        reg_wr(8'h1C, 32'h0000_005A);
        reg_wr(8'h24, 32'h0000_0001);
        reg_wr(8'h00, 32'h0);
        reg_rd(8'h04);
        check("vbp", d, 32'h0000_1200);
        reg_rd(8'h30);
        check("unmapped", d, 32'h0);
        fitlb <= 1'b1;
        t_itlb();
        t_age();
        t_bus();
        t_irq_dbg();
        complete_run();
    end
endmodule : event_entry_vectoring_tb_top

/* File: tb/irq_ctrl_model.sv */
`timescale 1ns/1ps
module irq_ctrl_model
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] raise_in,
    input wire logic accept_in,
    input wire logic [4:0] accept_idx_in,
    output logic [3:0] irq_lvl_out,
    output logic [13:0] autovector_out
);
    logic [3:0] pend_r;
    logic [13:0] idle_r;
    // A request stays up until the core reports that level taken
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pend_r <= 4'h0;
            idle_r <= 14'h0;
        end
        else
        begin
            idle_r <= ~idle_r;
            for (int l = 0; l < 4; l++)
            begin
                if (raise_in[l])
                    pend_r[l] <= 1'b1;
                else if (accept_in && accept_idx_in == 5'(10 - l))
                    pend_r[l] <= 1'b0;
            end
        end
    end
    assign irq_lvl_out = pend_r;
    // Highest level wins; offsets avoid the fixed slots, idle bus toggles
    always_comb
    begin
        if (pend_r[3])
            autovector_out = 14'h0280;
        else if (pend_r[2])
            autovector_out = 14'h0288;
        else if (pend_r[1])
            autovector_out = 14'h0380;
        else if (pend_r[0])
            autovector_out = 14'h0400;
        else
            autovector_out = idle_r;
    end
endmodule : irq_ctrl_model
